// file: rtl/light_sensor_i2c_regs.sv
/*
  Bus slave of the ambient light sensor: address match, register pointer,
  command register write, two-byte result read, and conversion control.
  Assumes scl and sda arrive already synchronous to ref_clk_in, with each
  bus phase lasting several clock cycles; the sda wire is pulled up outside.
*/
// Function
// - The device answers to bus address 0x44, written as byte 0x88 for a write.
// - The same address with the direction bit set is acknowledged and data is then driven out.
// - Pointer 0x01 returns both bytes of the conversion count within one read.
// - The result goes out low byte first, then high byte, each byte most significant bit first.
// - Pointer 0x00 with one data byte updates the command register, every byte acknowledged.
// - Command bit 7 set enables conversions.
// - Clearing the enable bit stops conversion and keeps all register contents.
// - Command bit 6 clear makes one conversion and then stops.
// - Command bit 5 clear converts visible light.
// - Command bits 4:2 at 001 give internal timing and a 12-bit result.
// - Range code 01 selects the 4000 lux full scale.
`timescale 1ns/10ps
`default_nettype none
module light_sensor_i2c_regs #(
  parameter int CONV_CYCLES = light_sensor_pkg::CONV_CYCLES_DEF
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Serial bus, sda open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // Analog core
  input wire light_sensor_pkg::sample_s sample_in,
  output logic [1:0] full_scale_range_out,
  output logic ir_select_out,
  output logic conv_busy_out
);

  localparam light_sensor_pkg::slave_s SLAVE_RESET = '{
    st: light_sensor_pkg::ST_IDLE,
    ph: light_sensor_pkg::PH_ADDR,
    cnt: light_sensor_pkg::BIT_FIRST,
    full: 1'b0,
    shift: 8'h00,
    ptr: light_sensor_pkg::PTR_RESET,
    rw: 1'b0,
    byte_hi: 1'b0,
    snap: light_sensor_pkg::RESULT_RESET,
    cmd: light_sensor_pkg::CMD_RESET,
    cmd_wr: 1'b0,
    scl_q: 1'b1,
    sda_q: 1'b1,
    drive: 1'b0,
    sda_lvl: 1'b0
  };

  light_sensor_pkg::slave_s st_r;
  light_sensor_pkg::slave_s st_nxt;
  logic [15:0] result;
  logic busy;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // Byte returned for the current pointer and byte position
  function automatic logic [7:0] tx_byte(input logic [7:0] ptr, input logic hi,
                                         input logic [15:0] snap,
                                         input light_sensor_pkg::cmd_s cmd);
    if (ptr == light_sensor_pkg::PTR_RESULT) begin
      tx_byte = hi ? snap[15:8] : snap[7:0];
    end else if (ptr == light_sensor_pkg::PTR_CMD) begin
      tx_byte = cmd;
    end else begin
      tx_byte = 8'h00;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  conv_sequencer #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_conv (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .cmd_in(st_r.cmd),
    .start_in(st_r.cmd_wr),
    .sample_in(sample_in),
    .busy_out(busy),
    .result_out(result)
  );

  ////////////////////////////////////////////////////////////////////////
  assign scl_rise = scl_in && !st_r.scl_q;
  assign scl_fall = !scl_in && st_r.scl_q;
  assign bus_start = scl_in && st_r.scl_q && st_r.sda_q && !sda_in;
  assign bus_stop = scl_in && st_r.scl_q && !st_r.sda_q && sda_in;

  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_q = scl_in;
    st_nxt.sda_q = sda_in;
    st_nxt.cmd_wr = 1'b0;
    st_nxt.sda_lvl = 1'b0;
    if (bus_start) begin
      // Repeated start keeps the pointer for the following read
      st_nxt.st = light_sensor_pkg::ST_RX;
      st_nxt.ph = light_sensor_pkg::PH_ADDR;
      st_nxt.cnt = light_sensor_pkg::BIT_FIRST;
      st_nxt.full = 1'b0;
      st_nxt.drive = 1'b0;
    end else if (bus_stop) begin
      st_nxt.st = light_sensor_pkg::ST_IDLE;
      st_nxt.drive = 1'b0;
    end else begin
      case (st_r.st)
        light_sensor_pkg::ST_IDLE: begin
          st_nxt.drive = 1'b0;
        end
        light_sensor_pkg::ST_RX: begin
          if (scl_rise) begin
            st_nxt.shift = {st_r.shift[6:0], sda_in};
            st_nxt.cnt = st_r.cnt + 1'b1;
            st_nxt.full = (st_r.cnt == light_sensor_pkg::BIT_LAST);
          end else if (scl_fall && st_r.full) begin
            st_nxt.full = 1'b0;
            st_nxt.st = light_sensor_pkg::ST_ACK;
            st_nxt.drive = 1'b1;
            case (st_r.ph)
              light_sensor_pkg::PH_ADDR: begin
                if (st_r.shift[7:1] == light_sensor_pkg::DEV_ADDR) begin
                  st_nxt.rw = st_r.shift[0];
                  st_nxt.snap = result;
                  st_nxt.byte_hi = 1'b0;
                end else begin
                  st_nxt.st = light_sensor_pkg::ST_IDLE;
                  st_nxt.drive = 1'b0;
                end
              end
              light_sensor_pkg::PH_PTR: begin
                st_nxt.ptr = st_r.shift;
              end
              light_sensor_pkg::PH_DATA: begin
                // Writes to the result pointer are acknowledged and dropped
                if (st_r.ptr == light_sensor_pkg::PTR_CMD) begin
                  st_nxt.cmd = st_r.shift;
                  st_nxt.cmd_wr = 1'b1;
                end
              end
              default: begin
                st_nxt.st = light_sensor_pkg::ST_IDLE;
                st_nxt.drive = 1'b0;
              end
            endcase
          end
        end
        light_sensor_pkg::ST_ACK: begin
          if (scl_fall) begin
            st_nxt.cnt = light_sensor_pkg::BIT_FIRST;
            if (st_r.rw) begin
              // Low byte leaves first, msb first
              st_nxt.shift = tx_byte(st_r.ptr, 1'b0, st_r.snap, st_r.cmd);
              st_nxt.drive = !st_nxt.shift[7];
              st_nxt.byte_hi = 1'b1;
              st_nxt.st = light_sensor_pkg::ST_TX;
            end else begin
              st_nxt.drive = 1'b0;
              st_nxt.st = light_sensor_pkg::ST_RX;
              st_nxt.ph = (st_r.ph == light_sensor_pkg::PH_ADDR) ? light_sensor_pkg::PH_PTR
                : light_sensor_pkg::PH_DATA;
            end
          end
        end
        light_sensor_pkg::ST_TX: begin
          if (scl_fall) begin
            if (st_r.cnt == light_sensor_pkg::BIT_LAST) begin
              st_nxt.drive = 1'b0;
              st_nxt.full = 1'b0;
              st_nxt.st = light_sensor_pkg::ST_MACK;
            end else begin
              st_nxt.shift = {st_r.shift[6:0], 1'b0};
              st_nxt.drive = !st_r.shift[6];
              st_nxt.cnt = st_r.cnt + 1'b1;
            end
          end
        end
        light_sensor_pkg::ST_MACK: begin
          if (scl_rise) begin
            // A nack ends the read; wait for stop or start
            if (sda_in) begin
              st_nxt.st = light_sensor_pkg::ST_IDLE;
            end else begin
              st_nxt.full = 1'b1;
            end
          end else if (scl_fall && st_r.full) begin
            // High byte follows the low one, then the pair repeats
            st_nxt.full = 1'b0;
            st_nxt.shift = tx_byte(st_r.ptr, st_r.byte_hi, st_r.snap, st_r.cmd);
            st_nxt.drive = !st_nxt.shift[7];
            st_nxt.byte_hi = !st_r.byte_hi;
            st_nxt.cnt = light_sensor_pkg::BIT_FIRST;
            st_nxt.st = light_sensor_pkg::ST_TX;
          end
        end
        default: begin
          st_nxt.st = light_sensor_pkg::ST_IDLE;
          st_nxt.drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_r <= SLAVE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign sda_out = st_r.sda_lvl;
  assign sda_oe_n_out = !st_r.drive;
  assign full_scale_range_out = st_r.cmd.full_scale_range;
  assign ir_select_out = st_r.cmd.ir_sel;
  assign conv_busy_out = busy;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence byte_in_done;
    !bus_start && !bus_stop && st_r.st == light_sensor_pkg::ST_RX && scl_fall && st_r.full;
  endsequence

  chk_write_addr_ack: assert property (byte_in_done ##0 st_r.ph == light_sensor_pkg::PH_ADDR
    && st_r.shift == {light_sensor_pkg::DEV_ADDR, 1'b0}
    |=> st_r.drive && !sda_oe_n_out && !st_r.rw)
    else $error("Write address not acknowledged");
  chk_read_addr_ack: assert property (byte_in_done ##0 st_r.ph == light_sensor_pkg::PH_ADDR
    && st_r.shift == {light_sensor_pkg::DEV_ADDR, 1'b1}
    |=> st_r.drive && st_r.rw && st_r.snap == $past(result))
    else $error("Read address not acknowledged");
  chk_foreign_addr: assert property (byte_in_done ##0 st_r.ph == light_sensor_pkg::PH_ADDR
    && st_r.shift[7:1] != light_sensor_pkg::DEV_ADDR
    |=> sda_oe_n_out && st_r.st == light_sensor_pkg::ST_IDLE)
    else $error("Foreign address acknowledged");
  chk_cmd_write: assert property (byte_in_done ##0 st_r.ph == light_sensor_pkg::PH_DATA
    && st_r.ptr == light_sensor_pkg::PTR_CMD
    |=> st_r.cmd == $past(st_r.shift) && st_r.drive ##1 full_scale_range_out == $past(st_r.shift[1:0], 2))
    else $error("Command write lost");
  chk_low_byte_first: assert property (!bus_start && !bus_stop && st_r.st == light_sensor_pkg::ST_ACK
    && scl_fall && st_r.rw && st_r.ptr == light_sensor_pkg::PTR_RESULT
    |=> st_r.shift == st_r.snap[7:0] && st_r.drive == !st_r.snap[7])
    else $error("Result low byte not sent first");
  chk_high_byte_next: assert property (!bus_start && !bus_stop && st_r.st == light_sensor_pkg::ST_MACK
    && scl_fall && st_r.full && st_r.byte_hi && st_r.ptr == light_sensor_pkg::PTR_RESULT
    |=> st_r.shift == st_r.snap[15:8])
    else $error("Result high byte not sent second");
  chk_msb_first: assert property (!bus_start && !bus_stop && st_r.st == light_sensor_pkg::ST_TX
    && scl_fall && st_r.cnt != light_sensor_pkg::BIT_LAST
    |=> sda_oe_n_out == $past(st_r.shift[6]))
    else $error("Data bit order wrong");
  chk_cmd_starts_conv: assert property (byte_in_done ##0 st_r.ph == light_sensor_pkg::PH_DATA
    && st_r.ptr == light_sensor_pkg::PTR_CMD && st_r.shift[7] && !busy |=> ##1 conv_busy_out)
    else $error("Enabled command did not start a conversion");

  // Start and stop override the byte state, so byte checks leave those cycles out
  chk_ptr_capture: assert property (byte_in_done ##0 st_r.ph == light_sensor_pkg::PH_PTR
    |=> st_r.ptr == $past(st_r.shift) && st_r.drive)
    else $error("Pointer byte lost or not acknowledged");
  chk_other_ptr_write: assert property (byte_in_done ##0 st_r.ph == light_sensor_pkg::PH_DATA
    && st_r.ptr != light_sensor_pkg::PTR_CMD |=> $stable(st_r.cmd) && st_r.drive)
    else $error("Write to another pointer changed the command");
  chk_range_field: assert property (st_r.cmd_wr
    |-> full_scale_range_out == $past(st_r.shift[1:0]))
    else $error("Range output does not follow command bits 1:0");
  chk_ir_field: assert property (st_r.cmd_wr
    |-> ir_select_out == $past(st_r.shift[5]))
    else $error("Sensing select does not follow command bit 5");
  chk_mode_field: assert property (st_r.cmd_wr
    |-> st_r.cmd.enable == $past(st_r.shift[7]) && st_r.cmd.continuous == $past(st_r.shift[6]))
    else $error("Mode bits do not follow command bits 7:6");
  chk_cmd_read_back: assert property (!bus_start && !bus_stop && st_r.st == light_sensor_pkg::ST_ACK
    && scl_fall && st_r.rw && st_r.ptr == light_sensor_pkg::PTR_CMD |=> st_r.shift == $past(st_r.cmd))
    else $error("Command read back differs");
  chk_nack_release: assert property (!bus_start && !bus_stop && st_r.st == light_sensor_pkg::ST_MACK
    && scl_rise && sda_in |=> sda_oe_n_out && st_r.st == light_sensor_pkg::ST_IDLE)
    else $error("Master nack did not end the read");
  chk_start_keeps_ptr: assert property (bus_start
    |=> sda_oe_n_out && st_r.st == light_sensor_pkg::ST_RX && st_r.ptr == $past(st_r.ptr))
    else $error("Start did not release sda or lost the pointer");
  chk_snap_steady: assert property (st_r.st == light_sensor_pkg::ST_TX |=> $stable(st_r.snap))
    else $error("Result snapshot changed within a read");
  cov_cmd_write: cover property (st_r.cmd_wr);
  cov_result_read: cover property (st_r.st == light_sensor_pkg::ST_TX && st_r.byte_hi
    && st_r.ptr == light_sensor_pkg::PTR_RESULT);
  cov_nack_end: cover property (st_r.st == light_sensor_pkg::ST_MACK && scl_rise && sda_in);

endmodule
`default_nettype wire

// file: rtl/light_sensor_pkg.sv
/*
  Shared constants and types of the light sensor register interface:
  bus address, register pointers, command fields, state encodings.
  Assumes a single 100 MHz clock domain for every user of the package.
*/
package light_sensor_pkg;

  // Bus address and register pointers
  localparam logic [6:0] DEV_ADDR = 7'h44;
  localparam logic [7:0] PTR_CMD = 8'h00;
  localparam logic [7:0] PTR_RESULT = 8'h01;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  // Resolution codes, command bits 4:2
  localparam logic [2:0] RES_16 = 3'h0;
  localparam logic [2:0] RES_12 = 3'h1;
  localparam logic [2:0] RES_8 = 3'h2;
  localparam logic [2:0] RES_4 = 3'h3;

  // Full scale range codes, command bits 1:0
  localparam logic [1:0] FSR_1000 = 2'h0;
  localparam logic [1:0] FSR_4000 = 2'h1;
  localparam logic [1:0] FSR_16000 = 2'h2;
  localparam logic [1:0] FSR_64000 = 2'h3;

  // Integration timing
  localparam int CLK_MHZ = 100;
  localparam int CONV_TIME_US = 100;
  localparam int CONV_CYCLES_DEF = CONV_TIME_US * CLK_MHZ;
  localparam int CNT_W = 16;

  // Result limits
  localparam logic [15:0] MAX_16 = 16'hffff;
  localparam logic [15:0] MAX_12 = 16'h0fff;
  localparam logic [15:0] MAX_8 = 16'h00ff;
  localparam logic [15:0] MAX_4 = 16'h000f;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  typedef struct packed {
    logic enable;
    logic continuous;
    logic ir_sel;
    logic [2:0] res;
    logic [1:0] full_scale_range;
  } cmd_s;

  localparam cmd_s CMD_RESET = cmd_s'(8'h00);

  typedef struct packed {
    logic [15:0] visible;
    logic [15:0] infrared;
  } sample_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } i2c_state_e;

  typedef enum logic [2:0] {
    PH_ADDR = 3'h1,
    PH_PTR = 3'h2,
    PH_DATA = 3'h4
  } phase_e;

  typedef struct packed {
    i2c_state_e st;
    phase_e ph;
    logic [2:0] cnt;
    logic full;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rw;
    logic byte_hi;
    logic [15:0] snap;
    cmd_s cmd;
    logic cmd_wr;
    logic scl_q;
    logic sda_q;
    logic drive;
    logic sda_lvl;
  } slave_s;

  typedef struct packed {
    logic busy;
    logic [CNT_W-1:0] cnt;
    logic [15:0] result;
    logic done;
  } conv_s;

  // Largest count for a resolution code
  function automatic logic [15:0] res_max(input logic [2:0] res);
    case (res)
      RES_16: res_max = MAX_16;
      RES_12: res_max = MAX_12;
      RES_8: res_max = MAX_8;
      RES_4: res_max = MAX_4;
      default: res_max = MAX_16;
    endcase
  endfunction

endpackage

// file: rtl/conv_sequencer.sv
/*
  Conversion sequencer: times one integration, clips the count to the
  chosen resolution and holds it as the result.
  Assumes the digital count of the analog core is valid whenever sampled.
*/
`timescale 1ns/10ps
`default_nettype none
module conv_sequencer #(
  parameter int CONV_CYCLES = light_sensor_pkg::CONV_CYCLES_DEF
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Command and samples
  input wire light_sensor_pkg::cmd_s cmd_in,
  input wire logic start_in,
  input wire light_sensor_pkg::sample_s sample_in,
  // Status and result
  output logic busy_out,
  output logic [15:0] result_out
);

  localparam logic [light_sensor_pkg::CNT_W-1:0] LAST_CNT =
    light_sensor_pkg::CNT_W'(CONV_CYCLES - 1);
  localparam light_sensor_pkg::conv_s CONV_RESET = '{busy: 1'b0, cnt: '0,
    result: light_sensor_pkg::RESULT_RESET, done: 1'b0};

  light_sensor_pkg::conv_s st_r;
  light_sensor_pkg::conv_s st_nxt;
  logic [15:0] raw;
  logic [15:0] lim;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    raw = cmd_in.ir_sel ? sample_in.infrared : sample_in.visible;
    lim = light_sensor_pkg::res_max(cmd_in.res);
    if (!cmd_in.enable) begin
      // Power down stops timing but keeps the result
      st_nxt.busy = 1'b0;
      st_nxt.cnt = '0;
    end else if (!st_r.busy) begin
      if (start_in) begin
        st_nxt.busy = 1'b1;
        st_nxt.cnt = '0;
      end
    end else if (st_r.cnt == LAST_CNT) begin
      st_nxt.done = 1'b1;
      st_nxt.result = (raw > lim) ? lim : raw;
      st_nxt.cnt = '0;
      st_nxt.busy = cmd_in.continuous;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_r <= CONV_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_out = st_r.busy;
  assign result_out = st_r.result;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  chk_enable_start: assert property (start_in && cmd_in.enable && !st_r.busy |=> st_r.busy)
    else $error("Conversion did not start");
  chk_powerdown_hold: assert property (!cmd_in.enable |=> !st_r.busy && $stable(st_r.result))
    else $error("Power down changed result or kept converting");
  chk_one_shot_stop: assert property (st_r.done && !$past(cmd_in.continuous) |-> !st_r.busy)
    else $error("One shot kept converting");
  chk_continuous_run: assert property (st_r.done && $past(cmd_in.continuous) |-> st_r.busy)
    else $error("Continuous conversion stopped");
  chk_res_clip: assert property (st_r.done && $past(cmd_in.res) == light_sensor_pkg::RES_12
    |-> st_r.result <= light_sensor_pkg::MAX_12)
    else $error("Result exceeds 12-bit full scale");
  cov_one_shot: cover property (st_r.done && !st_r.busy);
  cov_continuous: cover property (st_r.done && st_r.busy);

endmodule
`default_nettype wire

// file: verification/i2c_master_model.sv
/*
  Bus master model: start, repeated start, stop, byte write and byte read,
  with a settable phase length so it can run fast or slow.
  Assumes the bench resolves sda with a pull-up and runs a 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
  // Clock
  input wire logic ref_clk_in,
  // Bus
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out,
  // Byte or ack seen, one-cycle strobe
  output logic [7:0] got_out,
  output logic got_stb_out
);
  // Cycles per scl phase, never below 2
  int half_cyc = 4;

  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    got_out = 8'h00;
    got_stb_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic note(input logic [7:0] b);
    got_out = b;
    got_stb_out = 1'b1;
    tick(1);
    got_stb_out = 1'b0;
  endtask

  // Sample at the end of the high phase, when the slave has long settled
  task automatic pulse(output logic s);
    tick(half_cyc);
    scl_out = 1'b1;
    tick(half_cyc);
    s = sda_in;
    scl_out = 1'b0;
    tick(1);
  endtask

  task automatic start_c();
    sda_out = 1'b0;
    tick(half_cyc);
    scl_out = 1'b0;
    tick(1);
  endtask

  task automatic restart_c();
    sda_out = 1'b1;
    tick(half_cyc);
    scl_out = 1'b1;
    tick(half_cyc);
    sda_out = 1'b0;
    tick(half_cyc);
    scl_out = 1'b0;
    tick(1);
  endtask

  task automatic stop_c();
    sda_out = 1'b0;
    tick(half_cyc);
    scl_out = 1'b1;
    tick(half_cyc);
    sda_out = 1'b1;
    tick(half_cyc);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic wr_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_out = b[i];
      pulse(s);
    end
    sda_out = 1'b1;
    pulse(s);
    note({7'h00, ~s});
  endtask

  task automatic rd_byte(input logic last);
    logic s;
    logic [7:0] b;
    b = 8'h00;
    sda_out = 1'b1;
    for (int i = 0; i < 8; i++) begin
      pulse(s);
      b = {b[6:0], s};
    end
    sda_out = last;
    pulse(s);
    sda_out = 1'b1;
    note(b);
  endtask

  task automatic write_seq(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    start_c();
    wr_byte(a);
    wr_byte(p);
    wr_byte(d);
    stop_c();
  endtask

  // Pointer first, then re-address for read
  task automatic read_seq(input logic [7:0] p, input int n);
    start_c();
    wr_byte({light_sensor_pkg::DEV_ADDR, 1'b0});
    wr_byte(p);
    restart_c();
    wr_byte({light_sensor_pkg::DEV_ADDR, 1'b1});
    for (int k = 0; k < n; k++) begin
      rd_byte(k == n - 1);
    end
    stop_c();
  endtask
endmodule
`default_nettype wire

// file: verification/test_light_sensor_i2c_regs.sv
/*
  Self-checking bench of the light sensor bus slave.
  Assumes the master model's tasks are called from here, one at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module test_light_sensor_i2c_regs;
  localparam int CONV_N = 8;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic scl, sda_m, sda_line, dut_sda, dut_oe_n, ir_sel, busy, got_stb;
  logic busy_q = 1'b0;
  logic [1:0] range_code;
  logic [7:0] got;
  logic [31:0] lfsr_r = 32'h6c1f;
  logic [7:0] exp_q[$];
  light_sensor_pkg::sample_s sample_v = '0;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_rise = 0;

  // Open drain wire with pull-up
  assign sda_line = sda_m & (dut_oe_n | dut_sda);

  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  light_sensor_i2c_regs #(.CONV_CYCLES(CONV_N)) dut_u (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(dut_sda), .sda_oe_n_out(dut_oe_n), .sample_in(sample_v),
    .full_scale_range_out(range_code), .ir_select_out(ir_sel), .conv_busy_out(busy));

  i2c_master_model mst_u (.ref_clk_in(ref_clk_in), .sda_in(sda_line), .scl_out(scl),
    .sda_out(sda_m), .got_out(got), .got_stb_out(got_stb));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Saturated, not shifted
  function automatic logic [15:0] expect_count(input logic [7:0] c, input light_sensor_pkg::sample_s s);
    logic [15:0] v;
    logic [15:0] m;
    v = c[5] ? s.infrared : s.visible;
    case (c[4:2])
      3'h1: m = 16'h0fff;
      3'h2: m = 16'h00ff;
      3'h3: m = 16'h000f;
      default: m = 16'hffff;
    endcase
    return (v > m) ? m : v;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic new_sample(input int sh);
    repeat (32) lfsr_r = lfsr_next(lfsr_r);
    sample_v.visible = lfsr_r[15:0] >> sh;
    sample_v.infrared = lfsr_r[31:16] >> sh;
  endtask

  task automatic push_acks(input logic a);
    repeat (3) exp_q.push_back({7'h00, a});
  endtask

  task automatic wr_cmd(input logic [7:0] c);
    push_acks(1'b1);
    mst_u.write_seq({light_sensor_pkg::DEV_ADDR, 1'b0}, light_sensor_pkg::PTR_CMD, c);
  endtask

  // Bytes alternate low then high
  task automatic rd_reg(input logic [7:0] p, input int n, input logic [15:0] v);
    push_acks(1'b1);
    for (int k = 0; k < n; k++) begin
      exp_q.push_back(k[0] ? v[15:8] : v[7:0]);
    end
    mst_u.read_seq(p, n);
  endtask

  task automatic wait_idle();
    for (int k = 0; k < 100; k++) begin
      if (busy === 1'b0) return;
      tick(1);
    end
    n_mismatch++;
    $display("[FAIL] busy wait expected 0 seen %b", busy);
    final_report();
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watcher: oldest note against each byte or ack the master sees
  always @(posedge ref_clk_in) begin
    busy_q <= busy;
    if (busy === 1'b1 && busy_q === 1'b0) n_rise++;
    if (got_stb === 1'b1) begin
      if (exp_q.size() == 0) check("spare bus byte", 16'h0001, 16'h0000);
      else check("bus byte", {8'h00, got}, {8'h00, exp_q.pop_front()});
    end
  end

  initial begin
    logic [7:0] c;
    logic [15:0] v;
    int rises;
    tick(16);
    rst_in = 1'b0;
    tick(2);
    check("range after reset", {14'h0, range_code}, 16'h0000);
    check("busy after reset", {15'h0, busy}, 16'h0000);
    check("sda idle", {15'h0, dut_oe_n}, 16'h0001);
    push_acks(1'b0);
    mst_u.write_seq(8'h8a, light_sensor_pkg::PTR_CMD, 8'h85);
    check("range after foreign address", {14'h0, range_code}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      mst_u.half_cyc = 2 + 3 * (i % 2);
      c = {2'b10, i[0], i[2:0], i[1:0]};
      new_sample(3 * i);
      rises = n_rise;
      wr_cmd(c);
      check("range code", {14'h0, range_code}, {14'h0, c[1:0]});
      check("ir select", {15'h0, ir_sel}, {15'h0, c[5]});
      wait_idle();
      check("one conversion", 16'(n_rise), 16'(rises + 1));
      rd_reg(light_sensor_pkg::PTR_RESULT, 4, expect_count(c, sample_v));
    end
    mst_u.half_cyc = 4;
    new_sample(0);
    wr_cmd(8'hc4);
    check("busy continuous", {15'h0, busy}, 16'h0001);
    new_sample(2);
    tick(3 * CONV_N + 4);
    rd_reg(light_sensor_pkg::PTR_RESULT, 2, expect_count(8'hc4, sample_v));
    check("busy still on", {15'h0, busy}, 16'h0001);
    wr_cmd(8'h44);
    check("busy off", {15'h0, busy}, 16'h0000);
    v = expect_count(8'hc4, sample_v);
    rises = n_rise;
    new_sample(5);
    tick(3 * CONV_N);
    rd_reg(light_sensor_pkg::PTR_RESULT, 2, v);
    check("no conversion while off", 16'(n_rise), 16'(rises));
    push_acks(1'b1);
    mst_u.write_seq({light_sensor_pkg::DEV_ADDR, 1'b0}, light_sensor_pkg::PTR_RESULT, 8'hff);
    rd_reg(light_sensor_pkg::PTR_CMD, 1, 16'h0044);
    tick(4);
    check("notes left", 16'(exp_q.size()), 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
